/* hw/status_report_defines.svh */
// How it works
// - errors wait in a queue until the host asks for them
// - each entry is a signed 16-bit code; zero means no error
// - control commands under local-only operation are rejected with code -201
// - excess parameters or commands queue -223 and are not executed
// - safety overvoltage queues -999 and stays latched until power cycle
// - clear-status empties the error queue and the whole summary byte
// - reset enters remote, output off, overvoltage alarm and events cleared, error queue and safety latch kept
// - identify answers five fields: maker, model, serial, firmware, user text
// - summary bit 2 shows a non-empty error queue
// - summary bit 3 shows an enabled questionable event
// - summary bit 7 shows an enabled operation event
// - summary bits 0, 1, 4, 5 and 6 always stay zero
// - event bits latch only on rising condition bits
// - error read acknowledges the overvoltage alarm, clearing it only if cause is gone
// - questionable reads are 16 bits: condition, event, short form event
// - questionable enable is 0 to 32767 and resets all set
// - only enabled event bits raise a group summary bit
// - operation reads are 16 bits; short form equals event query
`ifndef STATUS_REPORT_DEFINES_SVH
`define STATUS_REPORT_DEFINES_SVH
`define ERR_NONE 16'sh0000
`define ERR_LOCAL 16'shFF37
`define ERR_TOO_MUCH 16'shFF21
`define ERR_SAFETY_OVP 16'shFC19
`define STB_ERR_BIT 2
`define STB_QUES_BIT 3
`define STB_OPER_BIT 7
`define QUES_OVP_BIT 0
`define QUES_REMOTE_BIT 10
`define QUES_DC_ON_BIT 11
`define OPER_CV_BIT 8
`define QUES_ENABLE_RESET 16'h7FFF
`define QUES_ENABLE_MAX 16'h7FFF
`define OPER_ENABLE_RESET 16'hFFFF
`define MAX_CMDS_PER_MSG 3'h5
`define ERRQ_DEPTH 8
`define IDN_FIELDS 3'h5
`endif

/* hw/status_report_pkg.sv */
package status_report_pkg;
    typedef enum logic [3:0] {
        CMD_CLS, CMD_RST, CMD_IDN_Q, CMD_STB_Q, CMD_ERR_Q,
        CMD_QUESTIONABLE_CONDITION_Q, CMD_QUES_EVENT_Q, CMD_QUES_SHORT_Q, CMD_QUES_ENAB_W, CMD_QUES_ENAB_Q,
        CMD_OPERATION_CONDITION_Q, CMD_OPER_EVENT_Q, CMD_OPER_SHORT_Q, CMD_OPER_ENAB_W, CMD_OPER_ENAB_Q,
        CMD_LOCK
    } cmd_e;
    typedef struct packed {
        cmd_e code;
        logic [15:0] data;
        logic [2:0] position;    // zero-based place of the command in its message
        logic param_excess;      // parser saw too many parameters
    } cmd_s;
    typedef enum logic [1:0] {RESP_VALUE, RESP_ERROR, RESP_IDN} resp_e;
    typedef struct packed {
        resp_e kind;
        logic [2:0] field;       // identify field index 0..4
        logic [15:0] data;
    } resp_s;
endpackage

/* hw/status_report.sv */
`timescale 1ns/100ps
`default_nettype none
`include "status_report_defines.svh"
module status_report #(
    parameter logic [15:0] MAKER_CODE = 16'h0001,    // arbitrary
    parameter logic [15:0] MODEL_CODE = 16'h0002,    // arbitrary
    parameter logic [15:0] SERIAL_CODE = 16'h0003,   // arbitrary
    parameter logic [15:0] FIRMWARE_CODE = 16'h0004, // arbitrary
    parameter logic [15:0] USER_TEXT_CODE = 16'h0005 // arbitrary
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_cmd_valid,
    input wire status_report_pkg::cmd_s i_cmd,
    input wire logic i_err_valid,
    input wire logic [15:0] i_err_code,
    input wire logic i_local_only,
    input wire logic i_overvoltage_alarm,
    input wire logic i_safety_ovp,
    input wire logic i_constant_voltage_flag,
    input wire logic [15:0] i_ques_extra,
    input wire logic [15:0] i_oper_extra,
    output logic o_resp_valid,
    output status_report_pkg::resp_s o_resp,
    output logic [7:0] o_status_summary_byte,
    output logic o_remote_active,
    output logic o_dc_on,
    output logic o_safety_latched,
    output logic o_cmd_rejected
);
    // ----------------------------------------------------------------
    // command qualification
    // ----------------------------------------------------------------
    logic excess;
    logic control_cmd;
    logic local_reject;
    logic exec;
    assign excess = i_cmd_valid && (i_cmd.param_excess || i_cmd.position >= `MAX_CMDS_PER_MSG);
    assign control_cmd = (i_cmd.code == status_report_pkg::CMD_RST) ||
                         (i_cmd.code == status_report_pkg::CMD_LOCK) ||
                         (i_cmd.code == status_report_pkg::CMD_QUES_ENAB_W) ||
                         (i_cmd.code == status_report_pkg::CMD_OPER_ENAB_W);
    assign local_reject = i_cmd_valid && !excess && control_cmd && i_local_only;
    assign exec = i_cmd_valid && !excess && !local_reject;

    logic do_cls;
    logic do_rst;
    logic do_err_read;
    assign do_cls = exec && i_cmd.code == status_report_pkg::CMD_CLS;
    assign do_rst = exec && i_cmd.code == status_report_pkg::CMD_RST;
    assign do_err_read = exec && i_cmd.code == status_report_pkg::CMD_ERR_Q;

    // ----------------------------------------------------------------
    // remote and output state
    // ----------------------------------------------------------------
    logic remote;
    logic dc_on;
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            remote <= 1'b0;
            dc_on <= 1'b0;
        end else if (do_rst) begin
            remote <= 1'b1;
            dc_on <= 1'b0;
        end else if (exec && i_cmd.code == status_report_pkg::CMD_LOCK) begin
            remote <= i_cmd.data[0];
        end else if (i_local_only) begin
            remote <= 1'b0; // front-panel local forces the unit out of remote
        end
    end

    // ----------------------------------------------------------------
    // alarms
    // ----------------------------------------------------------------
    logic ovp_latched;
    logic safety;
    // acknowledge only cleared causes; a live alarm wins over the clear
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ovp_latched <= 1'b0;
        end else if (i_overvoltage_alarm) begin
            ovp_latched <= 1'b1;
        end else if (do_err_read || do_rst) begin
            ovp_latched <= 1'b0;
        end
    end
    logic safety_prev;
    // safety latch, only reset leaves it
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            safety <= 1'b0;
            safety_prev <= 1'b0;
        end else begin
            safety_prev <= i_safety_ovp;
            if (i_safety_ovp) begin
                safety <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // condition, event, enable
    // ----------------------------------------------------------------
    logic [15:0] questionable_condition;
    logic [15:0] operation_condition;
    always_comb begin
        questionable_condition = i_ques_extra;
        questionable_condition[`QUES_OVP_BIT] = ovp_latched;
        questionable_condition[`QUES_REMOTE_BIT] = remote;
        questionable_condition[`QUES_DC_ON_BIT] = dc_on;
        operation_condition = i_oper_extra;
        operation_condition[`OPER_CV_BIT] = i_constant_voltage_flag;
    end

    logic [15:0] ques_prev;
    logic [15:0] oper_prev;
    logic [15:0] ques_event;
    logic [15:0] oper_event;
    logic [15:0] ques_enable;
    logic [15:0] oper_enable;
    logic ques_evt_clr;
    logic oper_evt_clr;
    assign ques_evt_clr = do_rst || do_cls || (exec &&
        (i_cmd.code == status_report_pkg::CMD_QUES_EVENT_Q ||
         i_cmd.code == status_report_pkg::CMD_QUES_SHORT_Q));
    assign oper_evt_clr = do_rst || do_cls || (exec &&
        (i_cmd.code == status_report_pkg::CMD_OPER_EVENT_Q ||
         i_cmd.code == status_report_pkg::CMD_OPER_SHORT_Q));

    // rising edges only; new edges win over a clear
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ques_prev <= 16'h0000;
            oper_prev <= 16'h0000;
            ques_event <= 16'h0000;
            oper_event <= 16'h0000;
        end else begin
            ques_prev <= questionable_condition;
            oper_prev <= operation_condition;
            ques_event <= (ques_event & ~{16{ques_evt_clr}}) | (questionable_condition & ~ques_prev);
            oper_event <= (oper_event & ~{16{oper_evt_clr}}) | (operation_condition & ~oper_prev);
        end
    end

    // enables reset all set, questionable top bit unwritable
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ques_enable <= `QUES_ENABLE_RESET;
            oper_enable <= `OPER_ENABLE_RESET;
        end else if (exec && i_cmd.code == status_report_pkg::CMD_QUES_ENAB_W) begin
            ques_enable <= i_cmd.data & `QUES_ENABLE_MAX;
        end else if (exec && i_cmd.code == status_report_pkg::CMD_OPER_ENAB_W) begin
            oper_enable <= i_cmd.data;
        end
    end

    // ----------------------------------------------------------------
    // error queue
    // ----------------------------------------------------------------
    logic [15:0] errq [`ERRQ_DEPTH];
    logic [2:0] rd_ptr;
    logic [2:0] wr_ptr;
    logic [3:0] count;
    logic push;
    logic pop;
    logic [15:0] push_code;
    // one entry per cycle; the safety alarm outranks the others
    always_comb begin
        push = 1'b1;
        push_code = `ERR_NONE;
        if (i_safety_ovp && !safety_prev) begin
            push_code = `ERR_SAFETY_OVP;
        end else if (i_cmd_valid && excess) begin
            push_code = `ERR_TOO_MUCH;
        end else if (local_reject) begin
            push_code = `ERR_LOCAL;
        end else if (i_err_valid) begin
            push_code = i_err_code;
        end else begin
            push = 1'b0;
        end
    end
    assign pop = do_err_read && count != 4'h0;

    // errors held for a query; full queue drops newest
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst || do_cls) begin
            rd_ptr <= 3'h0;
            wr_ptr <= 3'h0;
            count <= 4'h0;
        end else begin
            if (push && (count != 4'(`ERRQ_DEPTH) || pop)) begin
                errq[wr_ptr] <= push_code;
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            if (push && !pop && count != 4'(`ERRQ_DEPTH)) begin
                count <= count + 4'h1;
            end else if (pop && !push) begin
                count <= count - 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // summary byte
    // ----------------------------------------------------------------
    logic [7:0] next_stb;
    always_comb begin
        next_stb = 8'h00;
        next_stb[`STB_ERR_BIT] = count != 4'h0;
        next_stb[`STB_QUES_BIT] = |(ques_event & ques_enable);
        next_stb[`STB_OPER_BIT] = |(oper_event & oper_enable);
    end

    // ----------------------------------------------------------------
    // answers
    // ----------------------------------------------------------------
    logic [2:0] idn_left;
    logic [2:0] idn_field;
    // five identify fields, one answer per cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            idn_left <= 3'h0;
            idn_field <= 3'h0;
        end else if (idn_left != 3'h0) begin
            idn_left <= idn_left - 3'h1;
            idn_field <= idn_field + 3'h1;
        end else if (exec && i_cmd.code == status_report_pkg::CMD_IDN_Q) begin
            idn_left <= `IDN_FIELDS;
            idn_field <= 3'h0;
        end
    end

    function automatic logic [15:0] idn_value(input logic [2:0] f);
        unique case (f)
            3'h0: idn_value = MAKER_CODE;
            3'h1: idn_value = MODEL_CODE;
            3'h2: idn_value = SERIAL_CODE;
            3'h3: idn_value = FIRMWARE_CODE;
            default: idn_value = USER_TEXT_CODE;
        endcase
    endfunction

    // query answers appear one cycle after the command, identify fields one cycle later
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_resp_valid <= 1'b0;
            o_resp <= '0;
        end else if (idn_left != 3'h0) begin
            o_resp_valid <= 1'b1;
            o_resp <= {status_report_pkg::RESP_IDN, idn_field, idn_value(idn_field)};
        end else begin
            o_resp_valid <= exec && !control_cmd && i_cmd.code != status_report_pkg::CMD_CLS
                && i_cmd.code != status_report_pkg::CMD_IDN_Q;
            o_resp.kind <= status_report_pkg::RESP_VALUE;
            o_resp.field <= 3'h0;
            unique case (i_cmd.code)
                status_report_pkg::CMD_ERR_Q: begin
                    o_resp.kind <= status_report_pkg::RESP_ERROR;
                    o_resp.data <= (count != 4'h0) ? errq[rd_ptr] : `ERR_NONE;
                end
                status_report_pkg::CMD_STB_Q: o_resp.data <= {8'h00, next_stb};
                status_report_pkg::CMD_QUESTIONABLE_CONDITION_Q: o_resp.data <= questionable_condition;
                status_report_pkg::CMD_QUES_EVENT_Q,
                status_report_pkg::CMD_QUES_SHORT_Q: o_resp.data <= ques_event;
                status_report_pkg::CMD_QUES_ENAB_Q: o_resp.data <= ques_enable;
                status_report_pkg::CMD_OPERATION_CONDITION_Q: o_resp.data <= operation_condition;
                status_report_pkg::CMD_OPER_EVENT_Q,
                status_report_pkg::CMD_OPER_SHORT_Q: o_resp.data <= oper_event;
                status_report_pkg::CMD_OPER_ENAB_Q: o_resp.data <= oper_enable;
                default: o_resp.data <= 16'h0000;
            endcase
        end
    end

    // status outputs; clear-status empties byte via queue and events
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_status_summary_byte <= 8'h00;
            o_remote_active <= 1'b0;
            o_dc_on <= 1'b0;
            o_safety_latched <= 1'b0;
            o_cmd_rejected <= 1'b0;
        end else begin
            o_status_summary_byte <= next_stb;
            o_remote_active <= remote;
            o_dc_on <= dc_on;
            o_safety_latched <= safety;
            o_cmd_rejected <= excess || local_reject;
        end
    end
endmodule
`default_nettype wire

/* bench/status_report_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module status_report_checker (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_cmd_valid,
    input wire status_report_pkg::cmd_s i_cmd,
    input wire logic i_local_only,
    input wire logic i_safety_ovp,
    input wire logic o_resp_valid,
    input wire status_report_pkg::resp_s o_resp,
    input wire logic [7:0] o_status_summary_byte,
    input wire logic o_safety_latched,
    input wire logic o_cmd_rejected
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    logic ok;
    // ------------------------------------------------------------
    // accepted commands
    // ------------------------------------------------------------
    // refused commands must never reach the decoders
    assign ok = i_cmd_valid && i_cmd.position < 3'h5 && !i_cmd.param_excess;
    a_unused_bits: assert property ((o_status_summary_byte & 8'h73) == 8'h00)
        else $error("unused summary bit set");
    a_excess_reject: assert property (i_cmd_valid && !ok |=> o_cmd_rejected)
        else $error("excess command not rejected");
    a_excess_silent: assert property (i_cmd_valid && !ok |=> !o_resp_valid)
        else $error("excess command answered");
    a_local_reject: assert property (ok && i_local_only &&
        i_cmd.code == status_report_pkg::CMD_RST |=> o_cmd_rejected)
        else $error("control under local only not rejected");
    a_err_kind: assert property (ok && i_cmd.code == status_report_pkg::CMD_ERR_Q
        |=> o_resp_valid && o_resp.kind == status_report_pkg::RESP_ERROR)
        else $error("error query not answered");
    a_enab_range: assert property (ok &&
        i_cmd.code == status_report_pkg::CMD_QUES_ENAB_Q |=> o_resp_valid && !o_resp.data[15])
        else $error("questionable enable out of range");
    a_idn_fields: assert property (ok && i_cmd.code == status_report_pkg::CMD_IDN_Q
        |-> ##2 (o_resp_valid && o_resp.field == 3'h0) ##1 (o_resp_valid && o_resp.field == 3'h1)
        ##1 (o_resp_valid && o_resp.field == 3'h2) ##1 (o_resp_valid && o_resp.field == 3'h3)
        ##1 (o_resp_valid && o_resp.field == 3'h4))
        else $error("identify fields out of order");
    a_safety_set: assert property ($rose(i_safety_ovp) |-> ##[1:2] o_safety_latched)
        else $error("safety overvoltage not latched");
    a_safety_hold: assert property (o_safety_latched |=> o_safety_latched)
        else $error("safety latch released without reset");
    c_identify: cover property (ok && i_cmd.code == status_report_pkg::CMD_IDN_Q);
    c_reject: cover property (o_cmd_rejected);
    c_err_flag: cover property (o_status_summary_byte[2]);
endmodule
`default_nettype wire

/* bench/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic i_core_clk,
    output logic o_cmd_valid,
    output status_report_pkg::cmd_s o_cmd
);
    // ------------------------------------------------------------
    // remote host
    // ------------------------------------------------------------
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
    end
    // one command per call; a gap edge avoids a double drive of valid
    // places counted left to right
    task automatic send(status_report_pkg::cmd_e c, logic [15:0] d, logic [2:0] p, logic x);
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b1;
        o_cmd <= '{c, d, p, x};
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b0;
        o_cmd.data <= ~d; // stale data must not look valid
    endtask
endmodule
`default_nettype wire

/* bench/tb_status_report.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_status_report;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_cmd_valid;
    status_report_pkg::cmd_s i_cmd;
    logic i_err_valid = 1'b0;
    logic [15:0] i_err_code = 16'h0000;
    logic i_local_only = 1'b0;
    logic i_overvoltage_alarm = 1'b0;
    logic i_safety_ovp = 1'b0;
    logic i_constant_voltage_flag = 1'b0;
    logic [15:0] i_ques_extra = 16'h0000;
    logic o_resp_valid;
    status_report_pkg::resp_s o_resp;
    logic [7:0] o_status_summary_byte;
    logic o_remote_active;
    logic o_dc_on;
    logic o_safety_latched;
    logic o_cmd_rejected;
    logic [17:0] exp_q[$];
    logic [31:0] rng = 32'h9D9D;
    int err_count = 0;
    int total_checks = 0;
    always #50 i_core_clk = ~i_core_clk;
    host_model u_host_model (.i_core_clk(i_core_clk), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));
    status_report u_status_report (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_err_valid(i_err_valid),
        .i_err_code(i_err_code), .i_local_only(i_local_only),
        .i_overvoltage_alarm(i_overvoltage_alarm), .i_safety_ovp(i_safety_ovp),
        .i_constant_voltage_flag(i_constant_voltage_flag), .i_ques_extra(i_ques_extra),
        .i_oper_extra(16'h0000), .o_resp_valid(o_resp_valid), .o_resp(o_resp),
        .o_status_summary_byte(o_status_summary_byte), .o_remote_active(o_remote_active),
        .o_dc_on(o_dc_on), .o_safety_latched(o_safety_latched),
        .o_cmd_rejected(o_cmd_rejected));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_resp(logic [17:0] e, logic [17:0] g);
        total_checks++;
        if (e !== g) begin
            err_count++;
            $display("[FAIL] %0t answer exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_lvl(logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (e !== g) begin
            err_count++;
            $display("[FAIL] %0t level exp %h got %h", $time, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic do_cmd(status_report_pkg::cmd_e c, logic [15:0] d);
        u_host_model.send(c, d, 3'h0, 1'b0);
    endtask
    task automatic ask_v(status_report_pkg::cmd_e c, logic [15:0] v);
        exp_q.push_back({status_report_pkg::RESP_VALUE, v});
        do_cmd(c, 16'h0000);
    endtask
    task automatic ask_e(logic [15:0] v);
        exp_q.push_back({status_report_pkg::RESP_ERROR, v});
        do_cmd(status_report_pkg::CMD_ERR_Q, 16'h0000);
    endtask
    task automatic perr(logic [15:0] c);
        @(posedge i_core_clk);
        i_err_valid <= 1'b1;
        i_err_code <= c;
        @(posedge i_core_clk);
        i_err_valid <= 1'b0;
    endtask
    // answers are matched oldest note first; an unasked answer is a mismatch
    always @(posedge i_core_clk) begin
        if (o_resp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk_resp(18'h3FFFF, {o_resp.kind, o_resp.data});
            else chk_resp(exp_q.pop_front(), {o_resp.kind, o_resp.data});
        end
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        tick(3000);
        err_count++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        i_nrst <= 1'b1;
        tick(2);
        chk_lvl(8'h00, o_status_summary_byte);
        ask_v(status_report_pkg::CMD_QUES_ENAB_Q, 16'h7FFF);
        ask_e(16'h0000);
        i_overvoltage_alarm <= 1'b1;
        tick(3);
        ask_v(status_report_pkg::CMD_QUESTIONABLE_CONDITION_Q, 16'h0001);
        ask_e(16'h0000);
        ask_v(status_report_pkg::CMD_QUESTIONABLE_CONDITION_Q, 16'h0001);
        i_overvoltage_alarm <= 1'b0;
        ask_e(16'h0000);
        ask_v(status_report_pkg::CMD_QUESTIONABLE_CONDITION_Q, 16'h0000);
        ask_v(status_report_pkg::CMD_QUES_SHORT_Q, 16'h0001);
        ask_v(status_report_pkg::CMD_QUES_EVENT_Q, 16'h0000);
        perr(16'hFF9C);
        perr(16'hFF20);
        tick(3);
        chk_lvl(8'h04, o_status_summary_byte);
        ask_e(16'hFF9C);
        ask_e(16'hFF20);
        ask_e(16'h0000);
        tick(3);
        chk_lvl(8'h00, o_status_summary_byte);
        u_host_model.send(status_report_pkg::CMD_QUES_ENAB_W, 16'h0000, 3'h5, 1'b0);
        u_host_model.send(status_report_pkg::CMD_QUES_ENAB_W, 16'h0000, 3'h0, 1'b1);
        ask_v(status_report_pkg::CMD_QUES_ENAB_Q, 16'h7FFF);
        i_local_only <= 1'b1;
        do_cmd(status_report_pkg::CMD_OPER_ENAB_W, 16'h0000);
        ask_v(status_report_pkg::CMD_OPER_ENAB_Q, 16'hFFFF);
        do_cmd(status_report_pkg::CMD_RST, 16'h0000);
        i_local_only <= 1'b0;
        tick(2);
        chk_lvl(8'h00, {7'h00, o_remote_active});
        ask_e(16'hFF21);
        ask_e(16'hFF21);
        ask_e(16'hFF37);
        ask_e(16'hFF37);
        rng = xorshift(rng);
        do_cmd(status_report_pkg::CMD_QUES_ENAB_W, rng[15:0]);
        ask_v(status_report_pkg::CMD_QUES_ENAB_Q, rng[15:0] & 16'h7FFF);
        do_cmd(status_report_pkg::CMD_QUES_ENAB_W, 16'h0000);
        i_ques_extra <= 16'h0020;
        tick(4);
        chk_lvl(8'h00, o_status_summary_byte);
        i_ques_extra <= 16'h0000;
        tick(4);
        ask_v(status_report_pkg::CMD_QUES_EVENT_Q, 16'h0020);
        do_cmd(status_report_pkg::CMD_QUES_ENAB_W, 16'h7FFF);
        i_ques_extra <= 16'h0020;
        tick(4);
        chk_lvl(8'h08, o_status_summary_byte);
        ask_v(status_report_pkg::CMD_QUES_EVENT_Q, 16'h0020);
        i_ques_extra <= 16'h0000;
        i_constant_voltage_flag <= 1'b1;
        tick(4);
        chk_lvl(8'h80, o_status_summary_byte);
        ask_v(status_report_pkg::CMD_OPERATION_CONDITION_Q, 16'h0100);
        ask_v(status_report_pkg::CMD_OPER_SHORT_Q, 16'h0100);
        ask_v(status_report_pkg::CMD_OPER_EVENT_Q, 16'h0000);
        do_cmd(status_report_pkg::CMD_RST, 16'h0000);
        tick(3);
        chk_lvl(8'h01, {7'h00, o_remote_active});
        chk_lvl(8'h00, {7'h00, o_dc_on});
        ask_v(status_report_pkg::CMD_QUESTIONABLE_CONDITION_Q, 16'h0400);
        perr(16'hFF9C);
        do_cmd(status_report_pkg::CMD_CLS, 16'h0000);
        tick(3);
        chk_lvl(8'h00, o_status_summary_byte);
        ask_e(16'h0000);
        for (int i = 1; i < 6; i++) exp_q.push_back({status_report_pkg::RESP_IDN, 16'(i)});
        do_cmd(status_report_pkg::CMD_IDN_Q, 16'h0000);
        tick(6);
        i_safety_ovp <= 1'b1;
        tick(3);
        i_safety_ovp <= 1'b0;
        do_cmd(status_report_pkg::CMD_RST, 16'h0000);
        tick(2);
        chk_lvl(8'h01, {7'h00, o_safety_latched});
        ask_e(16'hFC19);
        tick(3);
        chk_lvl(8'h00, 8'(exp_q.size()));
        results();
    end
endmodule
bind status_report status_report_checker u_status_report_checker (.*);
`default_nettype wire
